/* File: pkg/gpio_port_pkg.sv */
`default_nettype none
package gpio_port_pkg;
  localparam int PIN_COUNT = 16;
  localparam int ADDR_WIDTH = 8;
  // Register byte addresses.
  localparam logic [7:0] OUT_LEVEL_STATE_ADDR = 8'h00;
  localparam logic [7:0] OUT_LEVEL_SET_ADDR = 8'h04;
  localparam logic [7:0] OUT_LEVEL_CLEAR_ADDR = 8'h08;
  localparam logic [7:0] OUT_ENABLE_STATE_ADDR = 8'h0C;
  localparam logic [7:0] OUT_ENABLE_SET_ADDR = 8'h10;
  localparam logic [7:0] OUT_ENABLE_CLEAR_ADDR = 8'h14;
  localparam logic [7:0] INPUT_LEVEL_ADDR = 8'h18;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h1C;
  localparam logic [7:0] IRQ_STATUS_CLEAR_ADDR = 8'h20;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h24;
  localparam logic [7:0] INPUT_ENABLE_ADDR = 8'h28;
  localparam logic [7:0] PIN_CONFIG_BASE_ADDR = 8'h40;
  localparam logic [7:0] PIN_IRQ_TYPE_BASE_ADDR = 8'h80;
  // Field positions.
  localparam int FUNC_SEL_LSB = 4;
  localparam int FUNC_SEL_MSB = 5;
  localparam int PULLUP_BIT = 7;
  localparam int IRQ_TYPE_LSB = 7;
  localparam int IRQ_TYPE_MSB = 9;
  localparam logic [1:0] PLAIN_IO_FUNCTION_CODE = 2'h1;
  // Reset values.
  localparam logic [15:0] OUT_LEVEL_RESET = 16'h0000;
  localparam logic [15:0] OUT_ENABLE_RESET = 16'h0000;
  localparam logic [15:0] INPUT_ENABLE_RESET = 16'hFFFF;
  localparam logic [15:0] IRQ_MASK_RESET = 16'h0000;
  localparam logic [1:0] FUNC_SEL_RESET = 2'h0;
  // Interrupt trigger encodings.
  typedef enum logic [2:0] {
    TRIG_OFF = 3'h0,
    TRIG_RISE = 3'h1,
    TRIG_FALL = 3'h2,
    TRIG_BOTH = 3'h3,
    TRIG_LOW = 3'h4,
    TRIG_HIGH = 3'h5
  } trig_t;
  typedef struct packed {
    logic [15:0] level;
    logic [15:0] enable;
  } pin_drive_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
endpackage : gpio_port_pkg
`default_nettype wire

/* File: rtl/gpio_port.sv */
// Function
// - Bits 4-5 select function; one means GPIO.
// - Config bit 7 enables pin pull-up.
// - Enable-set alias ones set enable bits.
// - Enable-clear alias ones clear enable bits.
// - Enable state register readable, writable, reports drivers.
// - Output-clear alias ones drive level low.
// - Output-set alias ones drive level high.
// - Output level register holds and returns levels.
// - Sixteen pins, pin n at bit n.
// - Input register bit mirrors pin level.
// - Input sampling enabled after reset.
// - Input valid only when input enabled.
// - Three-bit trigger type in bits 9:7.
// - Trigger sets sticky status bit until cleared.
// - Status-clear alias ones clear status bits.
`timescale 1ns/1ps
`default_nettype none
module gpio_port #(
  parameter int PINS = gpio_port_pkg::PIN_COUNT // Number of pins.
) (
  input wire logic ref_clk, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire gpio_port_pkg::bus_req_t busReq, // Register request.
  output logic [31:0] rdata, // Read data, one cycle after read.
  input wire logic [PINS-1:0] pinIn, // Pad input levels.
  output gpio_port_pkg::pin_drive_t pinDrive, // Pad output level and enable.
  output logic [PINS-1:0] pullupEn, // Pad pull-up enables.
  output logic [2*PINS-1:0] funcSel, // Per-pin function selects.
  output logic irq // Level interrupt.
);
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Per-pin words occupy two 64-byte windows; address bits 5:2 pick the pin.
  logic [PINS-1:0] wbits;
  logic [3:0] pinIdx;
  logic cfgHit;
  logic typeHit;
  assign wbits = busReq.wdata[PINS-1:0];
  assign pinIdx = busReq.addr[5:2];
  assign cfgHit = busReq.addr[7:6] == gpio_port_pkg::PIN_CONFIG_BASE_ADDR[7:6];
  assign typeHit = busReq.addr[7:6] == gpio_port_pkg::PIN_IRQ_TYPE_BASE_ADDR[7:6];
  // Fields of a configuration write, shared by the register logic and its checks.
  logic [1:0] funcField;
  logic pullBit;
  logic [2:0] typeField;
  assign funcField = busReq.wdata[gpio_port_pkg::FUNC_SEL_MSB:gpio_port_pkg::FUNC_SEL_LSB];
  assign pullBit = busReq.wdata[gpio_port_pkg::PULLUP_BIT];
  assign typeField = busReq.wdata[gpio_port_pkg::IRQ_TYPE_MSB:gpio_port_pkg::IRQ_TYPE_LSB];

  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  logic [PINS-1:0] syncA_reg;
  logic [PINS-1:0] syncB_reg;
  logic [PINS-1:0] prevIn_reg;
  // Two stages guard against metastability; only syncB is read by logic.
  // Reset leaves the edge history low, so a pin idling high looks like a rise; types start off to hide it.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
      prevIn_reg <= '0;
    end else begin
      syncA_reg <= pinIn;
      syncB_reg <= syncA_reg;
      prevIn_reg <= syncB_reg;
    end
  end

  // ----------------------------------------------------------------
  // Output level and enable
  // ----------------------------------------------------------------
  logic [PINS-1:0] outLevel_reg;
  logic [PINS-1:0] outEnable_reg;
  // Each alias has its own address, so one write touches one of them; zero bits are ignored.
  // A write to the state address replaces every bit; the aliases touch only the bits written as one.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      outLevel_reg <= gpio_port_pkg::OUT_LEVEL_RESET;
    end else if (busReq.wr) begin
      if (busReq.addr == gpio_port_pkg::OUT_LEVEL_STATE_ADDR) begin
        outLevel_reg <= wbits;
      end else if (busReq.addr == gpio_port_pkg::OUT_LEVEL_SET_ADDR) begin
        outLevel_reg <= outLevel_reg | wbits;
      end else if (busReq.addr == gpio_port_pkg::OUT_LEVEL_CLEAR_ADDR) begin
        outLevel_reg <= outLevel_reg & ~wbits;
      end
    end
  end

  // Output driver enables.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      outEnable_reg <= gpio_port_pkg::OUT_ENABLE_RESET;
    end else if (busReq.wr) begin
      if (busReq.addr == gpio_port_pkg::OUT_ENABLE_STATE_ADDR) begin
        outEnable_reg <= wbits;
      end else if (busReq.addr == gpio_port_pkg::OUT_ENABLE_SET_ADDR) begin
        outEnable_reg <= outEnable_reg | wbits;
      end else if (busReq.addr == gpio_port_pkg::OUT_ENABLE_CLEAR_ADDR) begin
        outEnable_reg <= outEnable_reg & ~wbits;
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-pin configuration
  // ----------------------------------------------------------------
  logic [1:0] funcSel_reg [PINS];
  logic [PINS-1:0] pullup_reg;
  logic [2:0] trigType_reg [PINS];
  logic [PINS-1:0] inEnable_reg;
  logic [PINS-1:0] irqMask_reg;
  // Software stores function number minus one; the block only keeps the code.
  // Four address bits pick the pin, so a write can never land outside the sixteen slots.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < PINS; i++) begin
        funcSel_reg[i] <= gpio_port_pkg::FUNC_SEL_RESET;
        trigType_reg[i] <= gpio_port_pkg::TRIG_OFF;
      end
      pullup_reg <= '0;
    end else if (busReq.wr && cfgHit) begin
      funcSel_reg[pinIdx] <= funcField;
      pullup_reg[pinIdx] <= pullBit;
    end else if (busReq.wr && typeHit) begin
      trigType_reg[pinIdx] <= typeField;
    end
  end

  // Input enables start on so the input register works untouched.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      inEnable_reg <= gpio_port_pkg::INPUT_ENABLE_RESET;
      irqMask_reg <= gpio_port_pkg::IRQ_MASK_RESET;
    end else if (busReq.wr) begin
      if (busReq.addr == gpio_port_pkg::INPUT_ENABLE_ADDR) begin
        inEnable_reg <= wbits;
      end else if (busReq.addr == gpio_port_pkg::IRQ_MASK_ADDR) begin
        irqMask_reg <= wbits;
      end
    end
  end

  // ----------------------------------------------------------------
  // Input level and interrupt detection
  // ----------------------------------------------------------------
  logic [PINS-1:0] inLevel;
  logic [PINS-1:0] trigHit;
  // A disabled input reads zero rather than a stale or floating level.
  assign inLevel = syncB_reg & inEnable_reg;

  // Edge detection compares the synchronised level with one cycle earlier.
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      unique case (trigType_reg[i])
        gpio_port_pkg::TRIG_RISE: trigHit[i] = inLevel[i] & ~prevIn_reg[i];
        gpio_port_pkg::TRIG_FALL: trigHit[i] = ~inLevel[i] & prevIn_reg[i] & inEnable_reg[i];
        gpio_port_pkg::TRIG_BOTH: trigHit[i] = inEnable_reg[i] & (syncB_reg[i] ^ prevIn_reg[i]);
        gpio_port_pkg::TRIG_LOW: trigHit[i] = inEnable_reg[i] & ~syncB_reg[i];
        gpio_port_pkg::TRIG_HIGH: trigHit[i] = inLevel[i];
        default: trigHit[i] = 1'b0;
      endcase
    end
  end

  logic [PINS-1:0] irqStatus_reg;
  logic [PINS-1:0] irqStatus_next;
  logic statusClrWr;
  assign statusClrWr = busReq.wr && (busReq.addr == gpio_port_pkg::IRQ_STATUS_CLEAR_ADDR);
  // A trigger in the clearing cycle wins so no event is lost.
  // Level types set the bit every cycle, so a clear only sticks once the level has gone.
  assign irqStatus_next = (irqStatus_reg & ~(statusClrWr ? wbits : '0)) | trigHit;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irqStatus_reg <= '0;
    end else begin
      irqStatus_reg <= irqStatus_next;
    end
  end

  // The interrupt line is an OR of registers, so it never glitches during a bus cycle.
  assign irq = |(irqStatus_reg & irqMask_reg);
  logic maskWr;
  logic [PINS-1:0] maskedHit;
  assign maskWr = busReq.wr && (busReq.addr == gpio_port_pkg::IRQ_MASK_ADDR);
  assign maskedHit = trigHit & irqMask_reg;

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [31:0] rdata_next;
  // Unmapped addresses and write-only aliases fall through to zero.
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (cfgHit) begin
      rdata_next[gpio_port_pkg::FUNC_SEL_MSB:gpio_port_pkg::FUNC_SEL_LSB] = funcSel_reg[pinIdx];
      rdata_next[gpio_port_pkg::PULLUP_BIT] = pullup_reg[pinIdx];
    end else if (typeHit) begin
      rdata_next[gpio_port_pkg::IRQ_TYPE_MSB:gpio_port_pkg::IRQ_TYPE_LSB] = trigType_reg[pinIdx];
    end else begin
      unique case (busReq.addr)
        gpio_port_pkg::OUT_LEVEL_STATE_ADDR: rdata_next[PINS-1:0] = outLevel_reg;
        gpio_port_pkg::OUT_ENABLE_STATE_ADDR: rdata_next[PINS-1:0] = outEnable_reg;
        gpio_port_pkg::INPUT_LEVEL_ADDR: rdata_next[PINS-1:0] = inLevel;
        gpio_port_pkg::IRQ_STATUS_ADDR: rdata_next[PINS-1:0] = irqStatus_reg;
        gpio_port_pkg::IRQ_MASK_ADDR: rdata_next[PINS-1:0] = irqMask_reg;
        gpio_port_pkg::INPUT_ENABLE_ADDR: rdata_next[PINS-1:0] = inEnable_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= busReq.rd ? rdata_next : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Pad outputs
  // ----------------------------------------------------------------
  // Pad controls come straight from registers, so they never glitch.
  assign pinDrive.level = outLevel_reg;
  assign pinDrive.enable = outEnable_reg;
  assign pullupEn = pullup_reg;
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      funcSel[2*i +: 2] = funcSel_reg[i];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Checks look at the sampled request and wait one cycle for the registered result.
  sequence setWrite_s;
    busReq.wr && busReq.addr == gpio_port_pkg::OUT_LEVEL_SET_ADDR;
  endsequence

  out_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    setWrite_s |=> ((outLevel_reg & $past(wbits)) == $past(wbits)))
    else $error("Output set alias did not raise level.");

  out_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    busReq.wr && busReq.addr == gpio_port_pkg::OUT_LEVEL_CLEAR_ADDR |=> ((outLevel_reg & $past(wbits)) == '0))
    else $error("Output clear alias did not lower level.");

  en_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    busReq.wr && busReq.addr == gpio_port_pkg::OUT_ENABLE_SET_ADDR |=>
      (pinDrive.enable == ($past(outEnable_reg) | $past(wbits))))
    else $error("Enable set alias wrong.");

  en_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    busReq.wr && busReq.addr == gpio_port_pkg::OUT_ENABLE_CLEAR_ADDR |=>
      (pinDrive.enable == ($past(outEnable_reg) & ~$past(wbits))))
    else $error("Enable clear alias wrong.");

  status_sticky_a: assert property (@(posedge ref_clk) disable iff (rst)
    (|irqStatus_reg) && !statusClrWr |=> ((irqStatus_reg & $past(irqStatus_reg)) == $past(irqStatus_reg)))
    else $error("Status bit dropped without clear.");

  status_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    statusClrWr |=> ((irqStatus_reg & $past(wbits) & ~$past(trigHit)) == '0))
    else $error("Status clear alias failed.");

  alias_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    busReq.rd && busReq.addr == gpio_port_pkg::OUT_LEVEL_SET_ADDR |=> rdata == 32'h0000_0000)
    else $error("Write-only alias read nonzero.");

  level_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    busReq.rd && !busReq.wr && busReq.addr == gpio_port_pkg::OUT_LEVEL_STATE_ADDR |=>
      rdata[PINS-1:0] == $past(outLevel_reg))
    else $error("Output level readback wrong.");

  input_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    busReq.rd && busReq.addr == gpio_port_pkg::INPUT_LEVEL_ADDR |=>
      rdata[PINS-1:0] == $past(inLevel))
    else $error("Input level readback wrong.");

  status_rise_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(|irqStatus_reg) |-> $past(trigHit) != '0)
    else $error("Status set without a trigger.");

  irq_rise_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(irq) |-> $past(maskedHit) != '0 || $past(maskWr))
    else $error("Interrupt rose without cause.");

  irq_fall_a: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(irq) |-> $past(statusClrWr) || $past(maskWr))
    else $error("Interrupt fell without clear or mask write.");

  en_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    busReq.wr && busReq.addr == gpio_port_pkg::OUT_ENABLE_STATE_ADDR |=> outEnable_reg == $past(wbits))
    else $error("Enable state write lost.");

  lvl_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    busReq.wr && busReq.addr == gpio_port_pkg::OUT_LEVEL_STATE_ADDR |=> outLevel_reg == $past(wbits))
    else $error("Output level write lost.");

  set_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
    setWrite_s |=>
      (outLevel_reg & ~$past(wbits)) == ($past(outLevel_reg) & ~$past(wbits)))
    else $error("Set alias disturbed unwritten bits.");

  clr_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
    busReq.wr && busReq.addr == gpio_port_pkg::OUT_LEVEL_CLEAR_ADDR |=>
      (outLevel_reg | $past(wbits)) == ($past(outLevel_reg) | $past(wbits)))
    else $error("Clear alias disturbed unwritten bits.");

  func_cfg_a: assert property (@(posedge ref_clk) disable iff (rst)
    busReq.wr && cfgHit |=> funcSel_reg[$past(pinIdx)] == $past(funcField))
    else $error("Function select write lost.");

  pullup_cfg_a: assert property (@(posedge ref_clk) disable iff (rst)
    busReq.wr && cfgHit |=> pullupEn[$past(pinIdx)] == $past(pullBit))
    else $error("Pull-up enable write lost.");

  type_cfg_a: assert property (@(posedge ref_clk) disable iff (rst)
    busReq.wr && typeHit |=> trigType_reg[$past(pinIdx)] == $past(typeField))
    else $error("Trigger type write lost.");

  input_mask_a: assert property (@(posedge ref_clk) disable iff (rst)
    busReq.rd && busReq.addr == gpio_port_pkg::INPUT_LEVEL_ADDR |=>
      (rdata[PINS-1:0] & ~$past(inEnable_reg)) == '0)
    else $error("Disabled input read nonzero.");

  status_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
    statusClrWr |=>
      (irqStatus_reg & $past(irqStatus_reg) & ~$past(wbits)) == ($past(irqStatus_reg) & ~$past(wbits)))
    else $error("Status clear dropped unwritten bits.");

  rdata_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
    !busReq.rd |=> rdata == 32'h0000_0000)
    else $error("Read data stood without a read.");

  alias_clr_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    busReq.rd && busReq.addr == gpio_port_pkg::OUT_LEVEL_CLEAR_ADDR |=> rdata == 32'h0000_0000)
    else $error("Clear alias read nonzero.");

  // Per-pin checks tie each trigger condition to its own status bit.
  for (genvar g = 0; g < PINS; g++) begin : g_pin
    sequence riseSeen_s;
      !syncB_reg[g] ##1 (syncB_reg[g] && inEnable_reg[g] && trigType_reg[g] == gpio_port_pkg::TRIG_RISE);
    endsequence
    sequence fallSeen_s;
      syncB_reg[g] ##1 (!syncB_reg[g] && inEnable_reg[g] && trigType_reg[g] == gpio_port_pkg::TRIG_FALL);
    endsequence
    rise_pin_a: assert property (@(posedge ref_clk) disable iff (rst)
      riseSeen_s |=> irqStatus_reg[g])
      else $error("Rising edge missed its status bit.");
    fall_pin_a: assert property (@(posedge ref_clk) disable iff (rst)
      fallSeen_s |=> irqStatus_reg[g])
      else $error("Falling edge missed its status bit.");
    both_pin_a: assert property (@(posedge ref_clk) disable iff (rst)
      inEnable_reg[g] && trigType_reg[g] == gpio_port_pkg::TRIG_BOTH && syncB_reg[g] != prevIn_reg[g] |=>
        irqStatus_reg[g])
      else $error("Edge missed its status bit.");
    low_pin_a: assert property (@(posedge ref_clk) disable iff (rst)
      inEnable_reg[g] && !syncB_reg[g] && trigType_reg[g] == gpio_port_pkg::TRIG_LOW |=> irqStatus_reg[g])
      else $error("Low level missed its status bit.");
    high_pin_a: assert property (@(posedge ref_clk) disable iff (rst)
      inEnable_reg[g] && syncB_reg[g] && trigType_reg[g] == gpio_port_pkg::TRIG_HIGH |=> irqStatus_reg[g])
      else $error("High level missed its status bit.");
  end
endmodule : gpio_port
`default_nettype wire

/* File: tb/gpio_pad_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// Pad model.
// ----
module gpio_pad_model (
  input wire logic ref_clk, // Clock for the float pattern.
  input wire gpio_port_pkg::pin_drive_t pinDrive, // Device drive.
  input wire logic [15:0] pullupEn, // Pull-up enables.
  input wire logic [15:0] extEn, // Bench drives the pad.
  input wire logic [15:0] extVal, // Bench pad level.
  output logic [15:0] pinIn // Pad levels.
);
  logic [15:0] floatPat = 16'h5A5A;
  // A floating pad toggles, so a stale level is never taken for a real one.
  always @(posedge ref_clk) floatPat <= ~floatPat;
  // The device driver wins over the bench, the bench over the pull-up.
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (pinDrive.enable[i]) pinIn[i] = pinDrive.level[i];
      else if (extEn[i]) pinIn[i] = extVal[i];
      else pinIn[i] = pullupEn[i] | floatPat[i];
    end
  end
endmodule : gpio_pad_model
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  gpio_port_pkg::bus_req_t busReq = '0;
  gpio_port_pkg::pin_drive_t pinDrive;
  logic [31:0] rdata, funcSel, d, fsM;
  logic [15:0] pinIn, pullupEn, enM, lvlM, inEnM, m, puM;
  logic [15:0] extEn = 16'hFFFF;
  logic [15:0] extVal = 16'h0000;
  logic [7:0] a;
  logic [2:0] t;
  logic irq, st, lv, on;
  int error_cnt = 0;
  int compares = 0;
  int seed = 59;
  int p;
  always #25 ref_clk = ~ref_clk;
  gpio_port #(.PINS(16)) dut (.ref_clk(ref_clk), .rst(rst), .busReq(busReq), .rdata(rdata), .pinIn(pinIn),
    .pinDrive(pinDrive), .pullupEn(pullupEn), .funcSel(funcSel), .irq(irq));
  gpio_pad_model pads (.ref_clk(ref_clk), .pinDrive(pinDrive), .pullupEn(pullupEn), .extEn(extEn),
    .extVal(extVal), .pinIn(pinIn));
  // ----
  // Bus tasks.
  // ----
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One idle cycle follows each strobe, so no task reassigns the bus in one step.
  // The write returns off the edge, so a check right after it sees settled outputs.
  task wr(input logic [7:0] ad, input logic [31:0] wd);
    @(posedge ref_clk);
    busReq <= '{addr: ad, wdata: wd, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    busReq <= '0;
    #1;
  endtask : wr
  task rd(input logic [7:0] ad, output logic [31:0] rv);
    @(posedge ref_clk);
    busReq <= '{addr: ad, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    busReq <= '0;
    #1 rv = rdata;
  endtask : rd
  task rdchk(input logic [7:0] ad, input logic [31:0] exp);
    logic [31:0] rv;
    rd(ad, rv);
    chk(rv, exp);
  endtask : rdchk
  task wrap_up;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  // The pad level that does not trigger, so the change away from it does.
  function automatic logic idle_lvl(input logic [2:0] ty);
    return ty == gpio_port_pkg::TRIG_FALL || ty == gpio_port_pkg::TRIG_LOW;
  endfunction : idle_lvl
  // The whole run needs far fewer than 40000 cycles.
  initial begin
    #2000000;
    error_cnt++;
    wrap_up();
  end
  // ----
  // Main sequence.
  // ----
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    extVal <= 16'($random(seed));
    rdchk(gpio_port_pkg::OUT_LEVEL_STATE_ADDR, 32'h0);
    rdchk(gpio_port_pkg::OUT_ENABLE_STATE_ADDR, 32'h0);
    rdchk(gpio_port_pkg::INPUT_ENABLE_ADDR, 32'h0000FFFF);
    rdchk(gpio_port_pkg::INPUT_LEVEL_ADDR, {16'h0, extVal});
    rdchk(gpio_port_pkg::OUT_LEVEL_SET_ADDR, 32'h0);
    rdchk(gpio_port_pkg::OUT_LEVEL_CLEAR_ADDR, 32'h0);
    rdchk(8'hFC, 32'h0);
    chk({31'h0, irq}, 32'h0);
    enM = 16'h0000;
    lvlM = 16'h0000;
    // Every output and enable alias and state register in turn with random words; the upper half must be dropped.
    for (int i = 0; i < 24; i++) begin
      d = $random(seed);
      m = d[15:0];
      case (i % 6)
        0: begin a = gpio_port_pkg::OUT_ENABLE_SET_ADDR; enM = enM | m; end
        1: begin a = gpio_port_pkg::OUT_ENABLE_CLEAR_ADDR; enM = enM & ~m; end
        2: begin a = gpio_port_pkg::OUT_ENABLE_STATE_ADDR; enM = m; end
        3: begin a = gpio_port_pkg::OUT_LEVEL_SET_ADDR; lvlM = lvlM | m; end
        4: begin a = gpio_port_pkg::OUT_LEVEL_CLEAR_ADDR; lvlM = lvlM & ~m; end
        default: begin a = gpio_port_pkg::OUT_LEVEL_STATE_ADDR; lvlM = m; end
      endcase
      wr(a, d);
      rdchk(gpio_port_pkg::OUT_ENABLE_STATE_ADDR, {16'h0, enM});
      rdchk(gpio_port_pkg::OUT_LEVEL_STATE_ADDR, {16'h0, lvlM});
      chk(pinDrive, {lvlM, enM});
    end
    // Driven pads read back their own level; disabled inputs read zero.
    for (int i = 0; i < 4; i++) begin
      extVal <= 16'($random(seed));
      inEnM = 16'($random(seed));
      wr(gpio_port_pkg::INPUT_ENABLE_ADDR, {16'h0, inEnM});
      repeat (4) @(posedge ref_clk);
      rdchk(gpio_port_pkg::INPUT_LEVEL_ADDR, {16'h0, ((enM & lvlM) | (~enM & extVal)) & inEnM});
    end
    wr(gpio_port_pkg::INPUT_ENABLE_ADDR, 32'h0000FFFF);
    for (int i = 0; i < 16; i++) begin
      d = $random(seed);
      fsM[2*i+:2] = d[5:4];
      puM[i] = d[7];
      wr(gpio_port_pkg::PIN_CONFIG_BASE_ADDR + 8'(4 * i), d);
    end
    chk(funcSel, fsM);
    chk({16'h0, pullupEn}, {16'h0, puM});
    wr(gpio_port_pkg::OUT_ENABLE_STATE_ADDR, 32'h0);
    extEn <= 16'h0000;
    repeat (4) @(posedge ref_clk);
    rd(gpio_port_pkg::INPUT_LEVEL_ADDR, d);
    chk({16'h0, d[15:0] & puM}, {16'h0, puM});
    wr(gpio_port_pkg::PIN_CONFIG_BASE_ADDR + 8'h30, {26'h0, gpio_port_pkg::PLAIN_IO_FUNCTION_CODE, 4'h0});
    chk({30'h0, funcSel[25:24]}, {30'h0, gpio_port_pkg::PLAIN_IO_FUNCTION_CODE});
    extEn <= 16'hFFFF;
    // Each trigger code but off on a random pin, the two unused codes too: idle, trigger, clear, return.
    for (int k = 1; k <= 7; k++) begin
      t = 3'(k);
      p = $random(seed) & 15;
      st = idle_lvl(t);
      lv = (t == gpio_port_pkg::TRIG_LOW) || (t == gpio_port_pkg::TRIG_HIGH);
      on = (t <= gpio_port_pkg::TRIG_HIGH);
      extVal[p] <= st;
      wr(gpio_port_pkg::IRQ_MASK_ADDR, 32'h1 << p);
      wr(gpio_port_pkg::PIN_IRQ_TYPE_BASE_ADDR + 8'(4 * p), {22'h0, t, 7'h0});
      repeat (4) @(posedge ref_clk);
      wr(gpio_port_pkg::IRQ_STATUS_CLEAR_ADDR, 32'hFFFFFFFF);
      rdchk(gpio_port_pkg::IRQ_STATUS_ADDR, 32'h0);
      extVal[p] <= ~st;
      repeat (4) @(posedge ref_clk);
      rdchk(gpio_port_pkg::IRQ_STATUS_ADDR, on ? (32'h1 << p) : 32'h0);
      chk({31'h0, irq}, {31'h0, on});
      wr(gpio_port_pkg::IRQ_STATUS_CLEAR_ADDR, ~(32'h1 << p));
      rdchk(gpio_port_pkg::IRQ_STATUS_ADDR, on ? (32'h1 << p) : 32'h0);
      wr(gpio_port_pkg::IRQ_STATUS_CLEAR_ADDR, 32'h1 << p);
      rdchk(gpio_port_pkg::IRQ_STATUS_ADDR, lv ? (32'h1 << p) : 32'h0);
      extVal[p] <= st;
      repeat (4) @(posedge ref_clk);
      rd(gpio_port_pkg::INPUT_LEVEL_ADDR, d);
      chk({31'h0, d[p]}, {31'h0, st});
      rdchk(gpio_port_pkg::IRQ_STATUS_ADDR, (lv || t == gpio_port_pkg::TRIG_BOTH) ? (32'h1 << p) : 32'h0);
      wr(gpio_port_pkg::IRQ_MASK_ADDR, 32'h0);
      #1 chk({31'h0, irq}, {31'h0, 1'b0});
      wr(gpio_port_pkg::PIN_IRQ_TYPE_BASE_ADDR + 8'(4 * p), 32'h0);
      wr(gpio_port_pkg::IRQ_STATUS_CLEAR_ADDR, 32'hFFFFFFFF);
    end
    wrap_up();
  end
endmodule : tb
`default_nettype wire
